// [logic/phb_bars.sv]
// Primary header timer/cacheline word and the two memory base registers
//
// Contract
// - Cacheline 4/8/16/32 words, else eight.
// - Read command chosen by transfer length.
// - Selftest, multifunction, layout fields read zero.
// - Message base is sixteen bits, 64K aligned.
// - Low 4K local queues, rest forwarded.
// - Zero base disables image unless allowed.
// - Message base writes need its enable bit.
// - Block size sets writable base bits.
// - Message image exists on primary only.
// - Message base low bits fixed, prefetch loadable.
// - Register base twenty bits, 4K aligned.
// - Register base low bits all read zero.
// - Register base writes need enable bit.
// - Processor-only fields ignore bus writes.
`timescale 1ns/1ps
`include "phb_map.svh"

module phb_bars #(
  parameter int BS_W = 4,
  parameter int LEN_W = 13
) (
  input wire logic clock,
  input wire logic rst,
  input wire phb_pkg::phb_req_t cfg_req,
  output phb_pkg::phb_rsp_t cfg_rsp,
  input wire phb_pkg::phb_req_t pb_req,
  output phb_pkg::phb_rsp_t pb_rsp,
  input wire logic zero_base_allowed,
  input wire logic register_base_write_enable,
  input wire logic message_base_write_enable,
  input wire logic [BS_W-1:0] image_block_size,
  input wire logic mem_space_enable,
  input wire logic prefetch_load,
  input wire logic prefetch_value,
  input wire phb_pkg::phb_mem_t mem_req,
  output phb_pkg::phb_claim_t claim,
  input wire logic rd_req,
  input wire logic [LEN_W-1:0] rd_len,
  output phb_pkg::phb_rdcmd_t rd_cmd,
  input wire logic tenure_start,
  input wire logic tenure_active,
  output logic tenure_expired
);

  phb_pkg::phb_state_t s_q;
  phb_pkg::phb_state_t s_d;
  logic [15:0] msg_mask;
  logic [5:0] cl_words;
  logic [LEN_W-1:0] cl_bytes;
  logic msg_enabled;
  logic reg_enabled;
  logic [15:0] msg_hi;
  logic [31:0] msg_off;
  logic msg_hit;
  logic msg_low;
  logic reg_hit;
  logic [11:0] reg_off;
  logic rd_short;
  logic rd_fits;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Cacheline code to word count
  function automatic logic [5:0] cl_decode(input logic [7:0] code);
    case (code)
      `PHB_CL_CODE_4: cl_decode = `PHB_CL_WORDS_4;
      `PHB_CL_CODE_8: cl_decode = `PHB_CL_WORDS_8;
      `PHB_CL_CODE_16: cl_decode = `PHB_CL_WORDS_16;
      `PHB_CL_CODE_32: cl_decode = `PHB_CL_WORDS_32;
      default: cl_decode = `PHB_CL_WORDS_8;
    endcase
  endfunction

  // Byte-lane merge of write data into a word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------------------------------------
  // Size mask and image enables
  // ----------------------------------------------------------------------
  // Base bits below the image size are fixed at zero
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      msg_mask[i] = (i >= int'(image_block_size));
    end
  end

  // Zero base turns the image off unless allowed
  always_comb begin
    msg_enabled = ((s_q.msg_ba & msg_mask) != 16'h0000) || zero_base_allowed;
    reg_enabled = (s_q.reg_ba != 20'h00000) || zero_base_allowed;
  end

  // Cacheline size in bytes
  always_comb begin
    cl_words = cl_decode(s_q.cacheline_words);
    cl_bytes = LEN_W'(cl_words) << `PHB_WORD_SHIFT;
  end

  // ----------------------------------------------------------------------
  // Memory claim decode
  // ----------------------------------------------------------------------
  // Base match per image, primary interface only
  always_comb begin
    msg_hi = mem_req.addr[31:`PHB_MSG_BA_LSB];
    msg_hit = mem_req.valid && mem_space_enable && msg_enabled &&
              ((msg_hi & msg_mask) == (s_q.msg_ba & msg_mask));
    reg_hit = mem_req.valid && mem_space_enable && reg_enabled &&
              (mem_req.addr[31:`PHB_REG_BA_LSB] == s_q.reg_ba);
  end

  // Offset inside each image; bits under the size mask count as offset
  always_comb begin
    msg_off = {msg_hi & ~msg_mask, mem_req.addr[`PHB_MSG_BA_LSB-1:0]};
    msg_low = (msg_off[31:`PHB_MSG_LOCAL_LSB] == 20'h00000);
    reg_off = mem_req.addr[`PHB_REG_BA_LSB-1:0];
  end

  // ----------------------------------------------------------------------
  // Read length classes
  // ----------------------------------------------------------------------
  // Under eight bytes, or within one cacheline
  always_comb begin
    rd_short = rd_len < LEN_W'(`PHB_SHORT_READ_BYTES);
    rd_fits = rd_len <= cl_bytes;
  end

  // ----------------------------------------------------------------------
  // Read view of the three words
  // ----------------------------------------------------------------------
  function automatic logic [31:0] read_word(input phb_pkg::phb_state_t s, input logic [7:0] a,
                                            input logic [15:0] m);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `PHB_OFF_TIMER_CACHELINE_WORDS: begin
        // Selftest, multifunction and layout bits stay zero
        r[`PHB_SELFTEST_LSB +: 8] = 8'h00;
        r[`PHB_LAYOUT_LSB +: 8] = 8'h00;
        r[`PHB_MASTER_TENURE_LIMIT_LSB +: 8] = s.master_tenure_limit;
        r[`PHB_CACHELINE_WORDS_LSB +: 8] = s.cacheline_words;
      end
      `PHB_OFF_MSG_BASE: begin
        r[`PHB_MSG_BA_LSB +: 16] = s.msg_ba & m;
        r[`PHB_PF_BIT] = s.msg_pf;
      end
      `PHB_OFF_REG_BASE: begin
        r[`PHB_REG_BA_LSB +: 20] = s.reg_ba;
      end
      default: r = 32'h0000_0000;
    endcase
    read_word = r;
  endfunction

  // ----------------------------------------------------------------------
  // Register writes, answers, claims and command choice
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    logic [31:0] cur;
    w = 32'h0000_0000;
    cur = 32'h0000_0000;
    s_d = s_q;

    // Configuration cycle write, host side
    s_d.cfg_rsp.ack = cfg_req.valid;
    s_d.cfg_rsp.rdata = cfg_req.valid && !cfg_req.write ?
                        read_word(s_q, cfg_req.addr, msg_mask) : 32'h0000_0000;
    if (cfg_req.valid && cfg_req.write) begin
      cur = read_word(s_q, cfg_req.addr, msg_mask);
      w = merge(cur, cfg_req.wdata, cfg_req.be);
      case (cfg_req.addr)
        `PHB_OFF_TIMER_CACHELINE_WORDS: begin
          s_d.master_tenure_limit = w[`PHB_MASTER_TENURE_LIMIT_LSB +: 8];
          s_d.cacheline_words = w[`PHB_CACHELINE_WORDS_LSB +: 8];
        end
        `PHB_OFF_MSG_BASE: begin
          if (message_base_write_enable) begin
            s_d.msg_ba = w[`PHB_MSG_BA_LSB +: 16] & msg_mask;
          end
          // Prefetch flag ignores bus writes
          s_d.msg_pf = s_q.msg_pf;
        end
        `PHB_OFF_REG_BASE: begin
          if (register_base_write_enable) begin
            s_d.reg_ba = w[`PHB_REG_BA_LSB +: 20];
          end
        end
        default: s_d.master_tenure_limit = s_q.master_tenure_limit;
      endcase
    end

    // Processor write, applied after the host so it wins a same-cycle clash
    s_d.pb_rsp.ack = pb_req.valid;
    s_d.pb_rsp.rdata = pb_req.valid && !pb_req.write ?
                       read_word(s_q, pb_req.addr, msg_mask) : 32'h0000_0000;
    if (pb_req.valid && pb_req.write) begin
      cur = read_word(s_d, pb_req.addr, msg_mask);
      w = merge(cur, pb_req.wdata, pb_req.be);
      case (pb_req.addr)
        `PHB_OFF_TIMER_CACHELINE_WORDS: begin
          s_d.master_tenure_limit = w[`PHB_MASTER_TENURE_LIMIT_LSB +: 8];
          s_d.cacheline_words = w[`PHB_CACHELINE_WORDS_LSB +: 8];
        end
        `PHB_OFF_MSG_BASE: begin
          if (message_base_write_enable) begin
            s_d.msg_ba = w[`PHB_MSG_BA_LSB +: 16] & msg_mask;
          end
          // Prefetch flag takes processor writes only
          s_d.msg_pf = w[`PHB_PF_BIT];
        end
        `PHB_OFF_REG_BASE: begin
          if (register_base_write_enable) begin
            s_d.reg_ba = w[`PHB_REG_BA_LSB +: 20];
          end
        end
        default: s_d.cacheline_words = s_d.cacheline_words;
      endcase
    end

    // Serial configuration load of the prefetch flag
    if (prefetch_load) begin
      s_d.msg_pf = prefetch_value;
    end

    // Claim result, registered for one cycle
    s_d.claim.msg_claim = msg_hit;
    s_d.claim.msg_local = msg_hit && msg_low;
    s_d.claim.msg_forward = msg_hit && !msg_low;
    s_d.claim.reg_claim = reg_hit;
    s_d.claim.reg_offset = reg_hit ? reg_off : 12'h000;

    // Read command by transfer length
    if (rd_req) begin
      if (rd_short) begin
        s_d.rdcmd = phb_pkg::PHB_CMD_MR;
      end else if (rd_fits) begin
        s_d.rdcmd = phb_pkg::PHB_CMD_MRL;
      end else begin
        s_d.rdcmd = phb_pkg::PHB_CMD_MRM;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q.master_tenure_limit <= `PHB_RST_MASTER_TENURE_LIMIT;
      s_q.cacheline_words <= `PHB_RST_CACHELINE_WORDS;
      s_q.msg_ba <= `PHB_RST_MSG_BA;
      s_q.msg_pf <= `PHB_RST_MSG_PF;
      s_q.reg_ba <= `PHB_RST_REG_BA;
      s_q.cfg_rsp <= '0;
      s_q.pb_rsp <= '0;
      s_q.claim <= '0;
      s_q.rdcmd <= phb_pkg::PHB_CMD_MR;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Master tenure timer
  // ----------------------------------------------------------------------
  // Limit comes straight from the programmed timer field
  phb_tenure_timer phb_tenure_timer_inst (
    .clock(clock),
    .rst(rst),
    .start(tenure_start),
    .active(tenure_active),
    .limit(s_q.master_tenure_limit),
    .expired(tenure_expired)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output but tenure_expired straight from the state register
  assign cfg_rsp = s_q.cfg_rsp;
  assign pb_rsp = s_q.pb_rsp;
  assign claim = s_q.claim;
  assign rd_cmd = s_q.rdcmd;

endmodule // phb_bars

// [logic/phb_map.svh]
// Offsets, field positions, reset values and codes of the primary header bank
`ifndef PHB_MAP_SVH
`define PHB_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PHB_OFF_TIMER_CACHELINE_WORDS 8'h0c
`define PHB_OFF_MSG_BASE 8'h10
`define PHB_OFF_REG_BASE 8'h14

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define PHB_CACHELINE_WORDS_LSB 0
`define PHB_MASTER_TENURE_LIMIT_LSB 8
`define PHB_MSG_BA_LSB 16
`define PHB_REG_BA_LSB 12
`define PHB_PF_BIT 3
`define PHB_MSG_LOCAL_LSB 12
`define PHB_SELFTEST_LSB 24
`define PHB_LAYOUT_LSB 16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PHB_RST_MASTER_TENURE_LIMIT 8'h00
`define PHB_RST_CACHELINE_WORDS 8'h00
`define PHB_RST_MSG_BA 16'h0000
`define PHB_RST_MSG_PF 1'b1
`define PHB_RST_REG_BA 20'h00000

// ----------------------------------------------------------------------
// Timing and decode constants
// ----------------------------------------------------------------------
`define PHB_MIN_TENURE 8'h08
`define PHB_SHORT_READ_BYTES 13'h0008
`define PHB_CL_CODE_4 8'h04
`define PHB_CL_CODE_8 8'h08
`define PHB_CL_CODE_16 8'h10
`define PHB_CL_CODE_32 8'h20
`define PHB_CL_WORDS_4 6'h04
`define PHB_CL_WORDS_8 6'h08
`define PHB_CL_WORDS_16 6'h10
`define PHB_CL_WORDS_32 6'h20
`define PHB_WORD_SHIFT 2

`endif

// [logic/phb_pkg.sv]
// Types shared by the primary header bank and its tenure timer
package phb_pkg;

  // Register access from either the configuration side or the processor
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } phb_req_t;

  // Answer to a register access
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } phb_rsp_t;

  // Memory transaction offered for claiming
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } phb_mem_t;

  // Claim result for one memory transaction
  typedef struct packed {
    logic msg_claim;
    logic msg_local;
    logic msg_forward;
    logic reg_claim;
    logic [11:0] reg_offset;
  } phb_claim_t;

  // Master read commands, published bus encodings
  typedef enum logic [3:0] {
    PHB_CMD_MR = 4'h6,
    PHB_CMD_MRL = 4'he,
    PHB_CMD_MRM = 4'hc
  } phb_rdcmd_t;

  // Tenure timer state
  typedef struct packed {
    logic [7:0] cnt;
    logic expired;
  } phb_tmr_state_t;

  // Header bank state
  typedef struct packed {
    logic [7:0] master_tenure_limit;
    logic [7:0] cacheline_words;
    logic [15:0] msg_ba;
    logic msg_pf;
    logic [19:0] reg_ba;
    phb_rsp_t cfg_rsp;
    phb_rsp_t pb_rsp;
    phb_claim_t claim;
    phb_rdcmd_t rdcmd;
  } phb_state_t;

endpackage

// [logic/phb_tenure_timer.sv]
// Master tenure timer counting bus clocks against the programmed limit
`timescale 1ns/1ps
`include "phb_map.svh"

module phb_tenure_timer (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic active,
  input wire logic [7:0] limit,
  output logic expired
);

  phb_pkg::phb_tmr_state_t s_q;
  phb_pkg::phb_tmr_state_t s_d;
  logic [7:0] eff_limit;

  // ----------------------------------------------------------------------
  // Limit floor and counting
  // ----------------------------------------------------------------------
  // Values below eight act as eight clocks
  always_comb begin
    eff_limit = (limit < `PHB_MIN_TENURE) ? `PHB_MIN_TENURE : limit;
  end

  // Count one per clock while the tenure lasts
  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.cnt = 8'h01;
    end else if (active && s_q.cnt < eff_limit) begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
    s_d.expired = (active || start) && (s_d.cnt >= eff_limit);
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;

endmodule // phb_tenure_timer

// [verification/phb_bars_sva.sv]
// Port checker for the primary header bank
`timescale 1ns/1ps

module phb_bars_sva #(
  parameter int LEN_W = 13
) (
  input wire logic clock,
  input wire logic rst,
  input wire phb_pkg::phb_req_t cfg_req,
  input wire phb_pkg::phb_rsp_t cfg_rsp,
  input wire phb_pkg::phb_req_t pb_req,
  input wire phb_pkg::phb_rsp_t pb_rsp,
  input wire logic mem_space_enable,
  input wire phb_pkg::phb_mem_t mem_req,
  input wire phb_pkg::phb_claim_t claim,
  input wire logic rd_req,
  input wire logic [LEN_W-1:0] rd_len,
  input wire phb_pkg::phb_rdcmd_t rd_cmd,
  input wire logic tenure_start,
  input wire logic tenure_active,
  input wire logic tenure_expired
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  chk_fixed_zero: assert property (cfg_req.valid && !cfg_req.write && cfg_req.addr == 8'h0c
    |=> cfg_rsp.ack && cfg_rsp.rdata[31:16] == 16'h0000) else $error("upper half not zero");
  chk_msg_lowbits: assert property (pb_req.valid && !pb_req.write && pb_req.addr == 8'h10
    |=> pb_rsp.ack && pb_rsp.rdata[15:4] == 12'h000 && pb_rsp.rdata[2:0] == 3'h0)
    else $error("message base low bits not fixed");
  chk_reg_lowbits: assert property (cfg_req.valid && !cfg_req.write && cfg_req.addr == 8'h14
    |=> cfg_rsp.rdata[11:0] == 12'h000) else $error("register base low bits not zero");

  // ----------------------------------------------------------------
  // Claims
  // ----------------------------------------------------------------
  chk_claim_idle: assert property (!mem_req.valid |=> claim == '0)
    else $error("claim without a request");
  chk_claim_space: assert property (mem_req.valid && !mem_space_enable
    |=> !claim.msg_claim && !claim.reg_claim) else $error("claim with decoding off");
  chk_msg_split: assert property (claim.msg_claim == (claim.msg_local ^ claim.msg_forward)
    && !(claim.msg_local && claim.msg_forward)) else $error("local and forward inconsistent");
  chk_local_range: assert property (mem_req.valid && mem_req.addr[15:12] != 4'h0
    |=> !claim.msg_local) else $error("local above first 4K");
  chk_reg_offset: assert property (mem_req.valid |=> claim.reg_offset ==
    (claim.reg_claim ? $past(mem_req.addr[11:0]) : 12'h000)) else $error("bad register offset");

  // ----------------------------------------------------------------
  // Read command and tenure timer
  // ----------------------------------------------------------------
  chk_short_read: assert property (rd_req && rd_len < 8 |=> rd_cmd == phb_pkg::PHB_CMD_MR)
    else $error("short read not plain read");
  chk_cmd_hold: assert property (!rd_req |=> $stable(rd_cmd))
    else $error("read command changed without request");
  chk_tenure_min: assert property (tenure_start |=> !tenure_expired [*7])
    else $error("tenure shorter than eight clocks");
  chk_tenure_drop: assert property (!tenure_active && !tenure_start |=> !tenure_expired)
    else $error("expired outside a tenure");
endmodule // phb_bars_sva

bind phb_bars phb_bars_sva #(.LEN_W(LEN_W)) phb_bars_sva_inst (
  .clock, .rst, .cfg_req, .cfg_rsp, .pb_req, .pb_rsp, .mem_space_enable, .mem_req,
  .claim, .rd_req, .rd_len, .rd_cmd, .tenure_start, .tenure_active, .tenure_expired
);

// [verification/phb_host_model.sv]
// Host model issuing single register accesses on one request port
`timescale 1ns/1ps

module phb_host_model (
  input wire logic clock,
  output phb_pkg::phb_req_t req
);
  initial req = '0;

  // One-cycle request; released address and data lines carry inverted values, valid, write and byte enables go low
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{1'h1, w, a, 4'hf, d};
    @(posedge clock);
    req <= '{1'h0, 1'h0, ~a, 4'h0, ~d};
  endtask
endmodule // phb_host_model

// [verification/tb_phb_bars.sv]
// Self-checking bench for the primary header bank
`timescale 1ns/1ps

module tb_phb_bars;
  logic clock = 1'h0;
  logic rst = 1'h1;
  phb_pkg::phb_req_t cfg_req, pb_req;
  phb_pkg::phb_rsp_t cfg_rsp, pb_rsp;
  logic zero_ok = 1'h0, reg_we = 1'h0, msg_we = 1'h0, mem_en = 1'h0;
  logic pf_ld = 1'h0, pf_val = 1'h0, rd_req = 1'h0, t_start = 1'h0, t_act = 1'h0, t_exp;
  logic [3:0] bsize = 4'h0;
  logic [12:0] rd_len = 13'h0000;
  phb_pkg::phb_mem_t mreq = '0;
  phb_pkg::phb_claim_t clm;
  phb_pkg::phb_rdcmd_t rd_cmd;
  logic [31:0] exp_q[$];
  logic [31:0] mb, rb;
  logic [7:0] cl_code[6] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h33};
  logic [12:0] cl_bytes[6] = '{13'h10, 13'h20, 13'h40, 13'h80, 13'h20, 13'h20};
  int n_errors = 0, checked = 0, k;

  // Clock
  initial forever #5 clock = ~clock;

  phb_bars phb_bars_inst (.clock(clock), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .pb_req(pb_req), .pb_rsp(pb_rsp), .zero_base_allowed(zero_ok),
    .register_base_write_enable(reg_we), .message_base_write_enable(msg_we),
    .image_block_size(bsize), .mem_space_enable(mem_en), .prefetch_load(pf_ld),
    .prefetch_value(pf_val), .mem_req(mreq), .claim(clm), .rd_req(rd_req), .rd_len(rd_len),
    .rd_cmd(rd_cmd), .tenure_start(t_start), .tenure_active(t_act), .tenure_expired(t_exp));
  phb_host_model cfg_host (.clock(clock), .req(cfg_req));
  phb_host_model pb_host (.clock(clock), .req(pb_req));

  // ----------------------------------------------------------------
  // Comparison and reporting
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (exp_q.size() != 0) n_errors++;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Answer monitor takes the oldest expected value
  always @(negedge clock)
    if (cfg_rsp.ack === 1'h1 || pb_rsp.ack === 1'h1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk(cfg_rsp.ack ? cfg_rsp.rdata : pb_rsp.rdata, exp_q.pop_front());
    end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic acc(input logic pb, input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    exp_q.push_back(e);
    if (pb) pb_host.access(w, a, d);
    else cfg_host.access(w, a, d);
  endtask

  task automatic mchk(input logic [31:0] a, input logic [15:0] e);
    @(posedge clock);
    mreq <= '{1'h1, a};
    @(posedge clock);
    mreq <= '{1'h0, ~a};
    @(negedge clock);
    chk({16'h0, clm}, {16'h0, e});
  endtask

  task automatic rchk(input logic [12:0] n, input logic [3:0] e);
    @(posedge clock);
    rd_req <= 1'h1;
    rd_len <= n;
    @(posedge clock);
    rd_req <= 1'h0;
    rd_len <= 13'($urandom);
    @(negedge clock);
    chk({28'h0, rd_cmd}, {28'h0, e});
  endtask

  task automatic tchk(input logic [7:0] lt, input int lim);
    acc(0, 1, 8'h0c, {16'h0, lt, 8'h0}, 0);
    @(posedge clock);
    t_start <= 1'h1;
    @(posedge clock);
    t_start <= 1'h0;
    t_act <= 1'h1;
    #1;
    k = 0;
    while (t_exp !== 1'h1 && k < 300) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk(k, lim - 1);
    @(posedge clock);
    t_act <= 1'h0;
    repeat (2) @(negedge clock);
    chk({31'h0, t_exp}, 0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(60848));
    mb = ($urandom & 32'h7fffffff) | 32'h10000;
    rb = $urandom | 32'h80001000;
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    acc(0, 0, 8'h0c, 0, 0);
    acc(0, 0, 8'h10, 0, 32'h8);
    acc(1, 0, 8'h14, 0, 0);
    acc(0, 1, 8'h0c, 32'hffffffff, 0);
    acc(0, 0, 8'h0c, 0, 32'h0000ffff);
    acc(0, 0, 8'h20, 0, 0);
    acc(0, 1, 8'h10, 32'hffffffff, 0);
    acc(0, 0, 8'h10, 0, 32'h8);
    @(posedge clock) msg_we <= 1'h1;
    acc(0, 1, 8'h10, mb & 32'hfffffff7, 0);
    acc(0, 0, 8'h10, 0, {mb[31:16], 16'h8});
    acc(1, 1, 8'h10, mb & 32'hfffffff7, 0);
    acc(1, 0, 8'h10, 0, {mb[31:16], 16'h0});
    @(posedge clock);
    pf_ld <= 1'h1;
    pf_val <= 1'h1;
    @(posedge clock);
    pf_ld <= 1'h0;
    acc(1, 0, 8'h10, 0, {mb[31:16], 16'h8});
    @(posedge clock) bsize <= 4'h2;
    acc(0, 1, 8'h10, mb | 32'h30000, 0);
    acc(0, 0, 8'h10, 0, {mb[31:18], 18'h8});
    @(posedge clock) bsize <= 4'h0;
    acc(0, 1, 8'h10, mb, 0);
    acc(1, 1, 8'h14, rb, 0);
    acc(1, 0, 8'h14, 0, 0);
    @(posedge clock) reg_we <= 1'h1;
    acc(1, 1, 8'h14, rb, 0);
    acc(0, 0, 8'h14, 0, {rb[31:12], 12'h0});
    // Claims with decoding on and off
    @(posedge clock) mem_en <= 1'h1;
    mchk({mb[31:16], 16'h0ffc}, 16'hc000);
    mchk({mb[31:16], 16'h1000}, 16'ha000);
    mchk({rb[31:12], 12'habc}, 16'h1abc);
    mchk(mb ^ 32'h40000000, 16'h0);
    @(posedge clock) mem_en <= 1'h0;
    mchk({rb[31:12], 12'h004}, 16'h0);
    @(posedge clock) mem_en <= 1'h1;
    acc(0, 1, 8'h10, 0, 0);
    mchk(32'h00000040, 16'h0);
    @(posedge clock) zero_ok <= 1'h1;
    mchk(32'h00000040, 16'hc000);
    // Read command for every cacheline code
    foreach (cl_code[i]) begin
      acc(0, 1, 8'h0c, {24'h0, cl_code[i]}, 0);
      rchk(13'($urandom % 8), 4'h6);
      rchk(cl_bytes[i], 4'he);
      rchk(cl_bytes[i] + 13'h1, 4'hc);
    end
    tchk(8'h05, 8);
    tchk(8'h00, 8);
    tchk(8'h0c, 12);
    // Second reset restores the prefetch flag
    @(posedge clock) rst <= 1'h1;
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    acc(1, 0, 8'h10, 0, 32'h8);
    repeat (3) @(posedge clock);
    final_report;
  end

  // Watchdog
  initial begin
    #100000;
    n_errors++;
    final_report;
  end
endmodule // tb_phb_bars
